// ### rtl/io_sync_pkg.sv
/*
 * Shared constants for the process-data sync and failsafe output block:
 * object indices and byte addresses, failsafe codes, reset values and timing.
 * Assumes a 125 MHz system clock and a 32-bit plain register port.
 */
package io_sync_pkg;
	localparam int ADDR_W = 10;
	localparam int CLK_NS = 8;

	// Object indices; the byte address is four times the index
	localparam logic [7:0] IDX_CAPS = 8'h05;
	localparam logic [7:0] IDX_FS_CODE = 8'h24;
	localparam logic [7:0] IDX_STORED_OUT = 8'h2f;
	localparam logic [7:0] IDX_CTRL = 8'h40;
	localparam logic [7:0] IDX_SYNC_POINT = 8'h41;
	localparam logic [7:0] IDX_CH_SEL = 8'h42;
	localparam logic [7:0] IDX_MIN_REPEAT = 8'h43;
	localparam logic [7:0] IDX_PROC_TIME = 8'h44;
	localparam logic [7:0] IDX_LEAD_TIME = 8'h45;
	localparam logic [7:0] IDX_STATUS = 8'h46;

	localparam logic [ADDR_W-1:0] ADR_CAPS = {IDX_CAPS, 2'b00};
	localparam logic [ADDR_W-1:0] ADR_FS_CODE = {IDX_FS_CODE, 2'b00};
	localparam logic [ADDR_W-1:0] ADR_STORED_OUT = {IDX_STORED_OUT, 2'b00};
	localparam logic [ADDR_W-1:0] ADR_CTRL = {IDX_CTRL, 2'b00};
	localparam logic [ADDR_W-1:0] ADR_SYNC_POINT = {IDX_SYNC_POINT, 2'b00};
	localparam logic [ADDR_W-1:0] ADR_CH_SEL = {IDX_CH_SEL, 2'b00};
	localparam logic [ADDR_W-1:0] ADR_MIN_REPEAT = {IDX_MIN_REPEAT, 2'b00};
	localparam logic [ADDR_W-1:0] ADR_PROC_TIME = {IDX_PROC_TIME, 2'b00};
	localparam logic [ADDR_W-1:0] ADR_LEAD_TIME = {IDX_LEAD_TIME, 2'b00};
	localparam logic [ADDR_W-1:0] ADR_STATUS = {IDX_STATUS, 2'b00};

	// Field positions
	localparam int CAPS_IN_SYNC_BIT = 0;
	localparam int CAPS_OUT_SYNC_BIT = 1;
	localparam int CTRL_SYNC_EN_BIT = 0;

	// Failsafe selection codes
	localparam logic [1:0] FS_ZERO = 2'h0;
	localparam logic [1:0] FS_FULL = 2'h1;
	localparam logic [1:0] FS_HOLD = 2'h2;
	localparam logic [1:0] FS_STORED = 2'h3;
	localparam logic [31:0] FS_CODE_MAX = 32'h00000003;

	// Reset values
	localparam logic [1:0] FS_CODE_RST = FS_ZERO;
	localparam logic SYNC_EN_RST = 1'b0;
	localparam logic [15:0] SYNC_POINT_RST = 16'h0000;

	// Timing figures reported to the station head, in ns
	localparam logic [15:0] MIN_REPEAT_NS = 16'h03e8;
	localparam logic [15:0] PROC_TIME_NS = 16'h00c8;
	localparam logic [15:0] LEAD_TIME_NS = 16'h0064;

	// Silence after which process data counts as missing
	localparam int WATCHDOG_NS = 100000;
	localparam int WATCHDOG_CYCLES = WATCHDOG_NS / CLK_NS;

	typedef enum logic [1:0] {ST_POWERON, ST_RUN, ST_FAILSAFE} run_state_e;
endpackage : io_sync_pkg

// ### rtl/sync_point_timer.sv
/*
 * Counts local bus clocks from each cycle start and pulses at the programmed
 * synchronisation point. Assumes cycle_start is a one-cycle pulse.
 */
`timescale 1ns/1ns
`default_nettype none
module sync_point_timer #(
	parameter int CNT_W = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cycle_start,
	input wire logic [CNT_W-1:0] sync_point,
	output logic sync_strobe
);
	logic [CNT_W-1:0] count;
	logic running;
	logic hit;

	assign hit = running && (count == sync_point);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
			running <= 1'b0;
		end else if (cycle_start) begin
			count <= '0;
			running <= 1'b1;
		end else if (hit) begin
			// One strobe per cycle; a missed point waits for the next start
			running <= 1'b0;
		end else if (running) begin
			count <= count + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_strobe <= 1'b0;
		end else begin
			sync_strobe <= hit && !cycle_start;
		end
	end
endmodule : sync_point_timer
`default_nettype wire

// ### rtl/pd_missing_detect.sv
/*
 * Watchdog on process-data arrivals: raises missing once LIMIT clocks pass
 * with no valid frame, drops it on the next valid frame.
 * Assumes valid is a one-cycle pulse per received frame.
 */
`timescale 1ns/1ns
`default_nettype none
module pd_missing_detect #(
	parameter int LIMIT = 12500
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic valid,
	output logic missing
);
	localparam int CW = $clog2(LIMIT + 1);
	localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);
	logic [CW-1:0] idle;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			idle <= '0;
			missing <= 1'b0;
		end else if (valid) begin
			idle <= '0;
			missing <= 1'b0;
		end else if (idle == LAST) begin
			missing <= 1'b1;
		end else begin
			idle <= idle + 1'b1;
		end
	end
endmodule : pd_missing_detect
`default_nettype wire

// ### rtl/io_sync_failsafe.sv
/*
 * Process-data output stage of an I/O module: switch-on and failsafe output
 * handling, optional synchronised input capture and output update, and the
 * register port used by the station head.
 * Assumes one clock, synchronous inputs and a master that never waits.
 */
// The strobed register port and the register offsets were decided locally.
// Notes on behaviour
// - Outputs stay at switch-on value until first data
// - Failsafe armed after first valid exchange
// - Missing data after arming selects failsafe outputs
// - Code 0 zeros, 1 full scale, 2 hold
// - Code 3 drives the stored failsafe output
// - Failsafe code writable and applied
// - Async update follows data arrival; inputs are captured every clock
// - All channels change at one instant
// - Capabilities report input and output sync flags
// - Repeat, processing and lead times readable
// - Capture and update at programmed sync point
// - Non-sync module transfers data immediately
// - Sync mode can be switched off
// - Writable stored output sized like process data
`timescale 1ns/1ns
`default_nettype none
module io_sync_failsafe #(
	parameter int NCH = 4,
	parameter int W = 16,
	parameter bit SYNC_CAPABLE = 1'b1,
	parameter int WATCHDOG_CYCLES = io_sync_pkg::WATCHDOG_CYCLES
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [io_sync_pkg::ADDR_W-1:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic pd_out_valid,
	input wire logic [NCH*W-1:0] pd_out_data,
	input wire logic cycle_start,
	input wire logic [NCH*W-1:0] in_pins,
	output logic [NCH*W-1:0] pd_in,
	output logic [NCH*W-1:0] out_value,
	output logic failsafe_active,
	output logic armed
);
	import io_sync_pkg::*;

	localparam int CS_W = (NCH > 1) ? $clog2(NCH) : 1;

	logic [1:0] rst_sync;
	logic rst_n;
	run_state_e state;
	logic [1:0] fs_code;
	logic sync_en;
	logic sync_mode;
	logic [15:0] sync_point;
	logic [CS_W-1:0] ch_sel;
	logic [NCH*W-1:0] stored;
	logic [NCH*W-1:0] fs_value;
	logic [NCH*W-1:0] pend;
	logic pend_valid;
	logic sync_strobe;
	logic missing;
	logic enter_fs;
	logic apply_now;
	logic [NCH*W-1:0] apply_data;
	logic [31:0] next_rdata;
	logic [15:0] lead_time;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	sync_point_timer #(.CNT_W(16)) u_timer (
		.clk(clk),
		.rst_n(rst_n),
		.cycle_start(cycle_start),
		.sync_point(sync_point),
		.sync_strobe(sync_strobe)
	);

	pd_missing_detect #(.LIMIT(WATCHDOG_CYCLES)) u_watch (
		.clk(clk),
		.rst_n(rst_n),
		.valid(pd_out_valid),
		.missing(missing)
	);

	// A module without sync support always runs asynchronously
	assign sync_mode = SYNC_CAPABLE && sync_en;
	// Returning data wins over a watchdog that fires in the same cycle
	assign enter_fs = (state == ST_RUN) && missing && !pd_out_valid;
	assign apply_now = sync_mode ? (sync_strobe && pend_valid) : pd_out_valid;
	assign apply_data = sync_mode ? pend : pd_out_data;
	assign lead_time = sync_mode ? LEAD_TIME_NS : 16'h0000;

	// Register writes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fs_code <= FS_CODE_RST;
			sync_en <= SYNC_EN_RST;
			sync_point <= SYNC_POINT_RST;
			ch_sel <= '0;
		end else if (wr) begin
			case (addr)
				ADR_FS_CODE: begin
					// Out-of-range codes are not saved
					if (wdata <= FS_CODE_MAX) begin
						fs_code <= wdata[1:0];
					end
				end
				ADR_CTRL: sync_en <= wdata[CTRL_SYNC_EN_BIT];
				ADR_SYNC_POINT: sync_point <= wdata[15:0];
				ADR_CH_SEL: begin
					if (wdata < 32'(NCH)) begin
						ch_sel <= wdata[CS_W-1:0];
					end
				end
				default: ;
			endcase
		end
	end

	// Per-channel stored value and failsafe choice
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				stored[c*W +: W] <= '0;
			end else if (wr && addr == ADR_STORED_OUT && ch_sel == CS_W'(c)) begin
				stored[c*W +: W] <= wdata[W-1:0];
			end
		end

		always_comb begin
			case (fs_code)
				FS_ZERO: fs_value[c*W +: W] = '0;
				FS_FULL: fs_value[c*W +: W] = '1;
				FS_HOLD: fs_value[c*W +: W] = out_value[c*W +: W];
				default: fs_value[c*W +: W] = stored[c*W +: W];
			endcase
		end
	end

	// Run state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_POWERON;
			armed <= 1'b0;
			failsafe_active <= 1'b0;
		end else begin
			case (state)
				ST_POWERON: begin
					if (pd_out_valid) begin
						state <= ST_RUN;
						armed <= 1'b1;
					end
				end
				ST_RUN: begin
					if (enter_fs) begin
						state <= ST_FAILSAFE;
						failsafe_active <= 1'b1;
					end
				end
				ST_FAILSAFE: begin
					if (pd_out_valid) begin
						state <= ST_RUN;
						failsafe_active <= 1'b0;
					end
				end
				default: state <= ST_POWERON;
			endcase
		end
	end

	// Data waiting for the sync point; dropped on failsafe so stale data never lands
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pend <= '0;
			pend_valid <= 1'b0;
		end else if (pd_out_valid) begin
			pend <= pd_out_data;
			pend_valid <= 1'b1;
		end else if (enter_fs || (sync_strobe && pend_valid) || !sync_mode) begin
			pend_valid <= 1'b0;
		end
	end

	// Whole output word changes at once
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_value <= '0;
		end else if (enter_fs) begin
			out_value <= fs_value;
		end else if (apply_now) begin
			out_value <= apply_data;
		end
	end

	// Inputs: every clock when async, only at the sync point otherwise
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pd_in <= '0;
		end else if (!sync_mode || sync_strobe) begin
			pd_in <= in_pins;
		end
	end

	always_comb begin
		next_rdata = 32'h00000000;
		case (addr)
			ADR_CAPS: begin
				next_rdata[CAPS_IN_SYNC_BIT] = SYNC_CAPABLE;
				next_rdata[CAPS_OUT_SYNC_BIT] = SYNC_CAPABLE;
			end
			ADR_FS_CODE: next_rdata = 32'(fs_code);
			ADR_STORED_OUT: next_rdata = 32'(stored[ch_sel*W +: W]);
			ADR_CTRL: next_rdata[CTRL_SYNC_EN_BIT] = sync_mode;
			ADR_SYNC_POINT: next_rdata = 32'(sync_point);
			ADR_CH_SEL: next_rdata = 32'(ch_sel);
			ADR_MIN_REPEAT: next_rdata = 32'(MIN_REPEAT_NS);
			ADR_PROC_TIME: next_rdata = 32'(PROC_TIME_NS);
			ADR_LEAD_TIME: next_rdata = 32'(lead_time);
			ADR_STATUS: next_rdata = {27'h0, missing, failsafe_active, armed, state};
			default: next_rdata = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 32'h00000000;
		end else begin
			rdata <= rd ? next_rdata : 32'h00000000;
		end
	end

	property p_poweron_zero;
		@(posedge clk) disable iff (!rst_n)
		(state == ST_POWERON) |-> (out_value == '0);
	endproperty
	a_poweron_zero: assert property (p_poweron_zero) else $error("output left switch-on value");

	property p_arm;
		@(posedge clk) disable iff (!rst_n)
		$rose(armed) |-> $past(pd_out_valid) && ($past(state) == ST_POWERON);
	endproperty
	a_arm: assert property (p_arm) else $error("armed without first valid data");

	property p_fs_entry;
		@(posedge clk) disable iff (!rst_n)
		enter_fs |=> (state == ST_FAILSAFE) && failsafe_active;
	endproperty
	a_fs_entry: assert property (p_fs_entry) else $error("failsafe not entered");

	property p_code_zero;
		@(posedge clk) disable iff (!rst_n)
		(enter_fs && fs_code == FS_ZERO) |=> (out_value == '0);
	endproperty
	a_code_zero: assert property (p_code_zero) else $error("zero failsafe wrong");

	property p_code_hold;
		@(posedge clk) disable iff (!rst_n)
		(enter_fs && fs_code == FS_HOLD) |=> $stable(out_value) ##1 (out_value == $past(out_value, 2) || pd_out_valid || $past(pd_out_valid));
	endproperty
	a_code_hold: assert property (p_code_hold) else $error("hold failsafe changed output");

	property p_code_stored;
		@(posedge clk) disable iff (!rst_n)
		(enter_fs && fs_code == FS_STORED) |=> (out_value == $past(stored));
	endproperty
	a_code_stored: assert property (p_code_stored) else $error("stored failsafe wrong");

	property p_code_write;
		@(posedge clk) disable iff (!rst_n)
		(wr && addr == ADR_FS_CODE && wdata <= FS_CODE_MAX) |=> (fs_code == $past(wdata[1:0]));
	endproperty
	a_code_write: assert property (p_code_write) else $error("failsafe code not stored");

	property p_async_update;
		@(posedge clk) disable iff (!rst_n)
		(!sync_mode && pd_out_valid) |=> (out_value == $past(pd_out_data));
	endproperty
	a_async_update: assert property (p_async_update) else $error("async update late");

	property p_sync_update;
		@(posedge clk) disable iff (!rst_n)
		(sync_mode && pd_out_valid && !sync_strobe && !enter_fs) |=> (out_value == $past(out_value));
	endproperty
	a_sync_update: assert property (p_sync_update) else $error("sync output moved early");

	property p_caps;
		@(posedge clk) disable iff (!rst_n)
		(rd && addr == ADR_CAPS) |=> (rdata[CAPS_OUT_SYNC_BIT] == SYNC_CAPABLE) ##1 (rdata == 32'h00000000 || $past(rd));
	endproperty
	a_caps: assert property (p_caps) else $error("capability flags wrong");

	property p_no_sync;
		@(posedge clk) disable iff (!rst_n)
		(wr && addr == ADR_CTRL && !wdata[CTRL_SYNC_EN_BIT]) |=> !sync_mode;
	endproperty
	a_no_sync: assert property (p_no_sync) else $error("sync mode not switched off");
endmodule : io_sync_failsafe
`default_nettype wire

// ### sim/station_head_model.sv
/*
 * Behavioural station head on the local bus: sends output process data
 * frames and local bus cycle start pulses when the bench asks for them.
 * Assumes requests arrive as one-cycle pulses set after a rising edge.
 */
`timescale 1ns/1ns
`default_nettype none
module station_head_model #(
	parameter int DW = 64
) (
	input wire logic clk,
	input wire logic frame_req,
	input wire logic [DW-1:0] frame_data,
	input wire logic tick_req,
	output logic pd_out_valid,
	output logic [DW-1:0] pd_out_data,
	output logic cycle_start
);
	// Between frames the data lines show the inverse of the last frame,
	// so stale data cannot pass as a frame; one process drives every output
	always @(posedge clk) begin
		pd_out_valid <= frame_req;
		pd_out_data <= frame_req ? frame_data : ~frame_data;
		cycle_start <= tick_req;
	end
endmodule : station_head_model
`default_nettype wire

// ### sim/io_sync_failsafe_test.sv
/*
 * Self-checking bench for the sync and failsafe output block.
 * Assumes the station head model beside it and a shortened watchdog count.
 */
`timescale 1ns/1ns
`default_nettype none
module io_sync_failsafe_test;
	import io_sync_pkg::*;
	localparam int WD = 40;
	localparam int DW = 64;
	logic clk;
	logic arst_n = 1'b0;
	logic [ADDR_W-1:0] addr;
	logic [31:0] wdata;
	logic wr;
	logic rd;
	logic [31:0] rdata;
	logic frame_req;
	logic [DW-1:0] frame_data;
	logic tick_req;
	logic pd_out_valid;
	logic [DW-1:0] pd_out_data;
	logic cycle_start;
	logic [DW-1:0] in_pins;
	logic [DW-1:0] pd_in;
	logic [DW-1:0] out_value;
	logic failsafe_active;
	logic armed;
	int err_total = 0;
	int checks = 0;
	logic [31:0] rd_q[$];
	logic [129:0] out_q[$];
	logic rd_hist = 1'b0;
	logic pr_hist = 1'b0;
	logic probe = 1'b0;
	logic [DW-1:0] exp_in;
	logic [DW-1:0] stored;
	logic [DW-1:0] d;
	logic [DW-1:0] fs_val;
	logic [15:0] s;

	station_head_model #(.DW(DW)) i_head (.clk(clk), .frame_req(frame_req),
		.frame_data(frame_data), .tick_req(tick_req), .pd_out_valid(pd_out_valid),
		.pd_out_data(pd_out_data), .cycle_start(cycle_start));

	io_sync_failsafe #(.NCH(4), .W(16), .SYNC_CAPABLE(1'b1), .WATCHDOG_CYCLES(WD)) i_dut (
		.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .pd_out_valid(pd_out_valid), .pd_out_data(pd_out_data),
		.cycle_start(cycle_start), .in_pins(in_pins), .pd_in(pd_in),
		.out_value(out_value), .failsafe_active(failsafe_active), .armed(armed));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic finish_test();
		$display("err_total=%0d checks=%0d", err_total, checks);
		if (err_total == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test

	task automatic cmp(input logic [129:0] got, input logic [129:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp

	// Strobe drops for a cycle after each access, so no signal is set twice in one step
	task automatic wreg(input logic [ADDR_W-1:0] a, input logic [31:0] v);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask : wreg

	task automatic rreg(input logic [ADDR_W-1:0] a, input logic [31:0] e);
		rd_q.push_back(e);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
	endtask : rreg

	task automatic look(input logic [DW-1:0] e, input logic fs, input logic arm);
		out_q.push_back({exp_in, fs, arm, e});
		probe <= 1'b1;
		@(posedge clk);
		probe <= 1'b0;
		@(posedge clk);
	endtask : look

	task automatic frame(input logic [DW-1:0] v);
		frame_data <= v;
		frame_req <= 1'b1;
		@(posedge clk);
		frame_req <= 1'b0;
		@(posedge clk);
	endtask : frame

	task automatic tick();
		tick_req <= 1'b1;
		@(posedge clk);
		tick_req <= 1'b0;
		@(posedge clk);
	endtask : tick

	always @(posedge clk) begin
		rd_hist <= rd;
		pr_hist <= probe;
	end

	always @(negedge clk) begin
		if (rd_hist)
			cmp({98'h0, rdata}, {98'h0, rd_q.pop_front()});
		if (pr_hist)
			cmp({pd_in, failsafe_active, armed, out_value}, out_q.pop_front());
	end

	initial begin
		repeat (5000) @(posedge clk);
		err_total++;
		finish_test();
	end

	initial begin
		addr = '0;
		wdata = '0;
		wr = 1'b0;
		rd = 1'b0;
		frame_req = 1'b0;
		frame_data = '0;
		tick_req = 1'b0;
		in_pins = '0;
		stored = '0;
		void'($urandom(52729));
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		exp_in = {$urandom(), $urandom()};
		in_pins <= exp_in;
		rreg(ADR_CAPS, 32'h3);
		rreg(ADR_MIN_REPEAT, {16'h0, MIN_REPEAT_NS});
		rreg(ADR_PROC_TIME, {16'h0, PROC_TIME_NS});
		rreg(ADR_LEAD_TIME, 32'h0);
		wreg(ADR_MIN_REPEAT, 32'h5);
		rreg(ADR_MIN_REPEAT, {16'h0, MIN_REPEAT_NS});
		rreg(ADR_FS_CODE, 32'h0);
		rreg(ADR_STATUS, 32'h0);
		rreg(10'h3fc, 32'h0);
		// Long silence before any frame must not arm the failsafe
		tick();
		repeat (WD + 4) @(posedge clk);
		look('0, 1'b0, 1'b0);
		d = {$urandom(), $urandom()};
		frame(d);
		look(d, 1'b0, 1'b1);
		rreg(ADR_STATUS, 32'h5);
		for (int code = 0; code < 4; code++) begin
			wreg(ADR_FS_CODE, code);
			rreg(ADR_FS_CODE, code);
			if (code == 3) begin
				for (int c = 0; c < 4; c++) begin
					s = 16'($urandom());
					stored[c*16 +: 16] = s;
					wreg(ADR_CH_SEL, c);
					wreg(ADR_STORED_OUT, {16'h0, s});
				end
				rreg(ADR_STORED_OUT, {16'h0, s});
			end
			d = {$urandom(), $urandom()};
			frame(d);
			repeat (WD - 4) @(posedge clk);
			look(d, 1'b0, 1'b1);
			repeat (6) @(posedge clk);
			fs_val = (code == 0) ? '0 : (code == 1) ? '1 : (code == 2) ? d : stored;
			look(fs_val, 1'b1, 1'b1);
			rreg(ADR_STATUS, 32'h1e);
		end
		wreg(ADR_FS_CODE, 32'h4);
		rreg(ADR_FS_CODE, 32'h3);
		wreg(ADR_CTRL, 32'h1);
		rreg(ADR_CTRL, 32'h1);
		rreg(ADR_LEAD_TIME, {16'h0, LEAD_TIME_NS});
		wreg(ADR_SYNC_POINT, 32'h5);
		rreg(ADR_SYNC_POINT, 32'h5);
		in_pins <= {$urandom(), $urandom()};
		d = {$urandom(), $urandom()};
		frame(d);
		look(stored, 1'b0, 1'b1);
		tick();
		look(stored, 1'b0, 1'b1);
		// One cycle before the programmed point lands: outputs and inputs still old
		repeat (3) @(posedge clk);
		look(stored, 1'b0, 1'b1);
		exp_in = in_pins;
		look(d, 1'b0, 1'b1);
		wreg(ADR_CTRL, 32'h0);
		rreg(ADR_CTRL, 32'h0);
		d = {$urandom(), $urandom()};
		frame(d);
		look(d, 1'b0, 1'b1);
		finish_test();
	end
endmodule : io_sync_failsafe_test
`default_nettype wire
